// ---- inc/cpu_ctl_pkg.sv ----
// Functional notes
// - Control registers reached only by control-register instructions in supervisor mode.
// - Reset loads every state word bit with its fixed reset value, except same-set enable: 0 without interrupt interface and shadow sets.
// - Register number 7 holds the exception cause.
// - Numbers 8 to 10 exist only with the translation unit, else reserved.
// - Number 11, fault injection, exists only with error-correction support.
// - Number 13, configuration, exists only with protection unit or error correction.
// - Numbers 14 and 15 exist only with the protection unit, else reserved.
// - Taking a nonmaskable interrupt sets the nonmaskable mode bit to 1; the code sets it only with the interrupt interface.
// - With interrupt interface and shadow sets, same-set enable 0 blocks external interrupts asking for the set in use.
// - With translation unit, copy current set to previous on break or handler-mode-0 exception.
// - Without translation unit, copy current set to previous on every exception.
// - The set copy happens only after the state word has been saved.
// - Any non-interrupt exception sets the current set field to zero.
// - Set fields use only the bits needed to number the implemented sets.
// - Unused high bits of the set fields read 0; software writes 0.
package cpu_ctl_pkg;
  localparam logic [4:0] CTL_STATE_WORD = 5'h00;
  localparam logic [4:0] CTL_CORE_ID = 5'h05;
  localparam logic [4:0] CTL_EXC_CAUSE = 5'h07;
  localparam logic [4:0] CTL_PAGE_ADDR = 5'h08;
  localparam logic [4:0] CTL_XLATE_ACC = 5'h09;
  localparam logic [4:0] CTL_XLATE_MISC = 5'h0A;
  localparam logic [4:0] CTL_FAULT_INJ = 5'h0B;
  localparam logic [4:0] CTL_FAULT_ADDR = 5'h0C;
  localparam logic [4:0] CTL_CORE_CFG = 5'h0D;
  localparam logic [4:0] CTL_REGION_BASE = 5'h0E;
  localparam logic [4:0] CTL_REGION_ACC = 5'h0F;
  // State word field positions
  localparam int SAME_SET_IRQ_ENABLE_BIT = 23;
  localparam int NMI_BIT = 22;
  localparam int PREV_LSB = 16;
  localparam int CUR_LSB = 10;
  localparam int SET_FIELD_W = 6;
  localparam int EH_BIT = 2;
  localparam int LOW_W = 10;
  // Reset values
  localparam logic [31:0] STATE_RST = 32'h0080_0000;
  localparam logic [31:0] REG_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_SAVED = 2'b01
  } seq_state_t;

  // Whether a control register number is implemented for a given build
  function automatic logic reg_exists(input logic [4:0] num, input logic mmu,
                                      input logic mpu, input logic ecc);
    logic ok;
    ok = 1'b0;
    case (num)
      CTL_STATE_WORD, CTL_CORE_ID, CTL_EXC_CAUSE, CTL_FAULT_ADDR: ok = 1'b1;
      CTL_PAGE_ADDR, CTL_XLATE_ACC, CTL_XLATE_MISC: ok = mmu;
      CTL_FAULT_INJ: ok = ecc;
      CTL_CORE_CFG: ok = mpu | ecc;
      CTL_REGION_BASE, CTL_REGION_ACC: ok = mpu;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction
endpackage

// ---- inc/ctl_access_if.sv ----
`timescale 1ns/1ns
// Filtered control-register access between the gate and the bank
interface ctl_access_if;
  logic rd;
  logic wr;
  logic present;
  logic [4:0] num;
  logic [31:0] wdata;
  modport gate (output rd, output wr, output present, output num, output wdata);
  modport bank (input rd, input wr, input present, input num, input wdata);
endinterface // ctl_access_if

// ---- hw/ctl_access_gate.sv ----
`timescale 1ns/1ns
module ctl_access_gate #(
  parameter bit HAS_MMU = 1'b0,
  parameter bit HAS_MPU = 1'b0,
  parameter bit HAS_ECC = 1'b0
) (
  input wire logic i_supervisor,
  input wire logic i_rd_req,
  input wire logic i_wr_req,
  input wire logic [4:0] i_reg_num,
  input wire logic [31:0] i_wr_data,
  output logic o_refused,
  ctl_access_if.gate acc
);
  import cpu_ctl_pkg::*;

  // Outside supervisor mode nothing reaches the bank
  assign acc.rd = i_rd_req & i_supervisor;
  assign acc.present = reg_exists(i_reg_num, HAS_MMU, HAS_MPU, HAS_ECC);
  // Absent numbers swallow writes so no stray storage appears
  assign acc.wr = i_wr_req & i_supervisor & acc.present;
  assign acc.num = i_reg_num;
  assign acc.wdata = i_wr_data;
  assign o_refused = (i_rd_req | i_wr_req) & ~i_supervisor;
endmodule // ctl_access_gate

// ---- hw/set_copy_sequencer.sv ----
`timescale 1ns/1ns
module set_copy_sequencer #(
  parameter bit HAS_MMU = 1'b0
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_exc_take,
  input wire logic i_exc_is_break,
  input wire logic i_handler_mode,
  output logic o_copy
);
  import cpu_ctl_pkg::*;

  seq_state_t state_q;
  seq_state_t state_d;
  logic copy_due;

  // Which exceptions move the current set into the previous set
  assign copy_due = HAS_MMU ? (i_exc_is_break | ~i_handler_mode) : 1'b1;

  // Copy one cycle after the save, so the saved word holds the old set
  always_comb begin
    state_d = state_q;
    o_copy = 1'b0;
    case (state_q)
      SEQ_IDLE: begin
        if (i_exc_take && copy_due) state_d = SEQ_SAVED;
      end
      SEQ_SAVED: begin
        o_copy = 1'b1;
        state_d = (i_exc_take && copy_due) ? SEQ_SAVED : SEQ_IDLE;
      end
      default: state_d = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) state_q <= SEQ_IDLE;
    else state_q <= state_d;
  end
endmodule // set_copy_sequencer

// ---- hw/cpu_control_status_regs.sv ----
`timescale 1ns/1ns
module cpu_control_status_regs #(
  parameter bit HAS_MMU = 1'b0,
  parameter bit HAS_MPU = 1'b0,
  parameter bit HAS_ECC = 1'b0,
  parameter bit HAS_EIC = 1'b0,
  parameter int NUM_SHADOW_SETS = 0,
  // Arbitrary identifier value, replace per build
  parameter logic [31:0] CORE_ID_VALUE = 32'h0000_0001
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_supervisor,
  input wire logic i_rd_req,
  input wire logic i_wr_req,
  input wire logic [4:0] i_reg_num,
  input wire logic [31:0] i_wr_data,
  input wire logic i_exc_take,
  input wire logic i_exc_is_irq,
  input wire logic i_exc_is_break,
  input wire logic i_exc_is_nmi,
  input wire logic [cpu_ctl_pkg::SET_FIELD_W-1:0] i_exc_set,
  input wire logic [31:0] i_exc_cause,
  input wire logic i_exc_addr_valid,
  input wire logic [31:0] i_exc_addr,
  input wire logic i_state_restore,
  input wire logic [31:0] i_restore_word,
  input wire logic [cpu_ctl_pkg::SET_FIELD_W-1:0] i_irq_req_set,
  output logic [31:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_access_refused,
  output logic [31:0] o_state_word,
  output logic [31:0] o_saved_word,
  output logic o_irq_set_ok
);
  import cpu_ctl_pkg::*;

  // Set field sizing: only enough bits to number every set
  localparam int NUM_SETS = NUM_SHADOW_SETS + 1;
  localparam int SET_W = (NUM_SETS > 1) ? $clog2(NUM_SETS) : 1;
  localparam bit HAS_SHADOW = (NUM_SHADOW_SETS > 0);
  localparam logic [SET_FIELD_W-1:0] SET_ONES = SET_FIELD_W'((1 << SET_W) - 1);
  localparam logic [SET_FIELD_W-1:0] SET_MASK = HAS_SHADOW ? SET_ONES : '0;

  // Bits software may change with a control write
  localparam logic [31:0] WR_MASK = {8'h00,
                                     (HAS_EIC && HAS_SHADOW),
                                     1'b0,
                                     SET_MASK,
                                     SET_MASK,
                                     {LOW_W{1'b1}}};
  // A restore from a saved copy may also bring back the nonmaskable bit
  localparam logic [31:0] RESTORE_MASK = WR_MASK | (32'(HAS_EIC) << NMI_BIT);

  ctl_access_if acc ();

  logic refused;
  logic copy_now;

  // Filtered access strobes
  ctl_access_gate #(
    .HAS_MMU(HAS_MMU),
    .HAS_MPU(HAS_MPU),
    .HAS_ECC(HAS_ECC)
  ) u_gate (
    .i_supervisor(i_supervisor),
    .i_rd_req(i_rd_req),
    .i_wr_req(i_wr_req),
    .i_reg_num(i_reg_num),
    .i_wr_data(i_wr_data),
    .o_refused(refused),
    .acc(acc)
  );

  // State word, its saved copy and the plain registers
  logic [31:0] state_q;
  logic [31:0] state_d;
  logic [31:0] saved_q;
  logic [31:0] saved_d;
  logic [31:0] cause_q;
  logic [31:0] cause_d;
  logic [31:0] opt_q [8:15];
  logic [31:0] rd_word;
  logic [31:0] rd_data_q;
  logic rd_valid_q;
  logic refused_q;
  logic irq_ok_q;
  logic irq_ok_d;

  // Field views of the state word
  wire [SET_FIELD_W-1:0] cur_set = state_q[CUR_LSB +: SET_FIELD_W];
  wire [SET_FIELD_W-1:0] saved_cur_set = saved_q[CUR_LSB +: SET_FIELD_W];
  wire handler_mode = state_q[EH_BIT];
  wire same_set_irq_enable = state_q[SAME_SET_IRQ_ENABLE_BIT];

  // Access decode
  wire wr_state = acc.wr && (acc.num == CTL_STATE_WORD);
  wire wr_cause = acc.wr && (acc.num == CTL_EXC_CAUSE);
  wire [31:0] masked_wdata = acc.wdata & WR_MASK;
  wire [31:0] masked_restore = i_restore_word & RESTORE_MASK;

  // Set entered by the exception: interrupts name one, the rest go to zero
  wire [SET_FIELD_W-1:0] entry_set = i_exc_is_irq ? (i_exc_set & SET_MASK)
                                                  : '0;

  set_copy_sequencer #(
    .HAS_MMU(HAS_MMU)
  ) u_seq (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_exc_take(i_exc_take),
    .i_exc_is_break(i_exc_is_break),
    .i_handler_mode(handler_mode),
    .o_copy(copy_now)
  );

  // Next state word. Hardware events win over software writes; the
  // previous-set copy comes from the saved word so it always sees the
  // set that was current before the exception.
  always_comb begin
    state_d = state_q;
    if (i_state_restore) begin
      state_d = masked_restore;
    end else if (wr_state) begin
      state_d = masked_wdata | (state_q & ~WR_MASK);
    end
    if (i_exc_take) begin
      state_d[CUR_LSB +: SET_FIELD_W] = entry_set;
      if (i_exc_is_nmi && HAS_EIC) begin
        state_d[NMI_BIT] = 1'b1;
      end
    end
    if (copy_now) begin
      state_d[PREV_LSB +: SET_FIELD_W] = saved_cur_set & SET_MASK;
    end
  end

  // The saved copy is taken in the exception cycle itself
  always_comb begin
    saved_d = saved_q;
    if (i_exc_take) begin
      saved_d = state_q;
    end
  end

  // Cause register: software writable, loaded by each exception
  always_comb begin
    cause_d = cause_q;
    if (wr_cause) begin
      cause_d = acc.wdata;
    end
    if (i_exc_take) begin
      cause_d = i_exc_cause;
    end
  end

  // State word and saved copy
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= STATE_RST & (WR_MASK | RESTORE_MASK);
      saved_q <= REG_RST;
    end else begin
      state_q <= state_d;
      saved_q <= saved_d;
    end
  end

  // Cause register storage
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) cause_q <= REG_RST;
    else cause_q <= cause_d;
  end

  // Registers 8 to 15, optional except 12; absent ones are tied to zero
  genvar gi;
  generate
    for (gi = 8; gi <= 15; gi++) begin : g_opt
      localparam logic [4:0] IDX = 5'(gi);
      localparam bit PRESENT = reg_exists(IDX, HAS_MMU, HAS_MPU, HAS_ECC);
      if (PRESENT) begin : g_live
        wire sw_wr = acc.wr && (acc.num == IDX);
        // Only the faulting address is also loaded by hardware
        wire hw_ld = (IDX == CTL_FAULT_ADDR) && i_exc_take && i_exc_addr_valid;
        logic [31:0] nxt;
        assign nxt = hw_ld ? i_exc_addr : (sw_wr ? acc.wdata : opt_q[gi]);
        always_ff @(posedge i_core_clk or negedge i_rst_n) begin
          if (!i_rst_n) opt_q[gi] <= REG_RST;
          else opt_q[gi] <= nxt;
        end
      end else begin : g_absent
        assign opt_q[gi] = REG_RST;
      end
    end
  endgenerate

  // Read selection; unknown and absent numbers give zero
  always_comb begin
    rd_word = REG_RST;
    if (acc.present) begin
      case (acc.num)
        CTL_STATE_WORD: rd_word = state_q;
        CTL_CORE_ID: rd_word = CORE_ID_VALUE;
        CTL_EXC_CAUSE: rd_word = cause_q;
        CTL_PAGE_ADDR,
        CTL_XLATE_ACC,
        CTL_XLATE_MISC,
        CTL_FAULT_INJ,
        CTL_FAULT_ADDR,
        CTL_CORE_CFG,
        CTL_REGION_BASE,
        CTL_REGION_ACC: rd_word = opt_q[{1'b1, acc.num[2:0]}];
        default: rd_word = REG_RST;
      endcase
    end
  end

  // Read answer is registered, one cycle after the request
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_data_q <= REG_RST;
      rd_valid_q <= 1'b0;
    end else begin
      rd_data_q <= acc.rd ? rd_word : rd_data_q;
      rd_valid_q <= acc.rd;
    end
  end

  // Refusals are reported one cycle later, for as long as the request is held
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) refused_q <= 1'b0;
    else refused_q <= refused;
  end

  // External interrupt gate: a request for the set in use passes only
  // with the same-set enable. Without the interface and shadow sets the
  // enable bit does not exist, so nothing is held back.
  assign irq_ok_d = !(HAS_EIC && HAS_SHADOW)
                    || same_set_irq_enable
                    || ((i_irq_req_set & SET_MASK) != cur_set);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) irq_ok_q <= 1'b0;
    else irq_ok_q <= irq_ok_d;
  end

  // Outputs straight from flip-flops
  assign o_rd_data = rd_data_q;
  assign o_rd_valid = rd_valid_q;
  assign o_access_refused = refused_q;
  assign o_state_word = state_q;
  assign o_saved_word = saved_q;
  assign o_irq_set_ok = irq_ok_q;
endmodule // cpu_control_status_regs

// ---- sim/core_exc_model.sv ----
`timescale 1ns/1ns
module core_exc_model (
  input wire logic i_core_clk,
  output logic o_supervisor,
  output logic o_exc_take,
  output logic o_exc_is_irq,
  output logic o_exc_is_break,
  output logic o_exc_is_nmi,
  output logic [5:0] o_exc_set,
  output logic [31:0] o_exc_cause,
  output logic [31:0] o_exc_addr
);
  // Idle core: supervisor mode, nothing taken
  initial begin
    o_supervisor = 1'b1;
    o_exc_take = 1'b0;
    o_exc_is_irq = 1'b0;
    o_exc_is_break = 1'b0;
    o_exc_is_nmi = 1'b0;
    o_exc_set = 6'h00;
    o_exc_cause = 32'h0000_0000;
    o_exc_addr = 32'h0000_0000;
  end
  // Mode changes only between instructions, so only just after an edge
  task automatic set_mode(input logic sup);
    o_supervisor = sup;
  endtask
  // One-cycle take, then a cycle for the set copy; stale set and cause are scrambled
  task automatic take(input logic irq, input logic nmi, input logic [5:0] set,
                      input logic [31:0] cause, input logic brk);
    o_exc_is_break = brk;
    o_exc_is_irq = irq;
    o_exc_is_nmi = nmi;
    o_exc_set = set;
    o_exc_cause = cause;
    o_exc_addr = ~cause;
    o_exc_take = 1'b1;
    @(posedge i_core_clk);
    #1;
    o_exc_take = 1'b0;
    o_exc_set = ~set;
    o_exc_cause = ~cause;
    @(posedge i_core_clk);
    #1;
  endtask
endmodule // core_exc_model

// ---- sim/cpu_control_status_regs_properties.sv ----
`timescale 1ns/1ns
module csr_checker
  import cpu_ctl_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_supervisor,
  input wire logic i_rd_req,
  input wire logic i_wr_req,
  input wire logic i_exc_take,
  input wire logic i_exc_is_irq,
  input wire logic i_exc_is_nmi,
  input wire logic i_state_restore,
  input wire logic [cpu_ctl_pkg::SET_FIELD_W-1:0] i_irq_req_set,
  input wire logic o_rd_valid,
  input wire logic o_access_refused,
  input wire logic [31:0] o_state_word,
  input wire logic [31:0] o_saved_word,
  input wire logic o_irq_set_ok
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  a_reset_word_value: assert property ($rose(i_rst_n) |-> o_state_word == 32'h0080_0000)
    else $error("state word not at reset value");
  a_read_answer_time: assert property (i_rd_req && i_supervisor |=> o_rd_valid)
    else $error("read not answered one cycle later");
  a_user_access_refused: assert property ((i_rd_req || i_wr_req) && !i_supervisor
    |=> o_access_refused && !o_rd_valid) else $error("user mode access not refused");
  a_nmi_bit_set: assert property (i_exc_take && i_exc_is_nmi && !i_state_restore
    |=> o_state_word[NMI_BIT]) else $error("nmi bit not set");
  a_current_set_cleared: assert property (i_exc_take && !i_exc_is_irq && !i_state_restore
    |=> o_state_word[15:10] == 6'h00) else $error("current set not cleared");
  a_saved_before_copy: assert property (i_exc_take |=> o_saved_word == $past(o_state_word))
    else $error("saved word is not the old state word");
  a_previous_set_copy: assert property (i_exc_take ##1 !i_exc_take && !i_state_restore
    && !i_wr_req |=> o_state_word[21:16] == $past(o_saved_word[15:10]))
    else $error("previous set not copied");
  a_set_high_zero: assert property (o_state_word[15:12] == 4'h0 && o_state_word[21:18] == 4'h0)
    else $error("unused set bits not zero");
  a_reserved_word_zero: assert property (o_state_word[31:24] == 8'h00)
    else $error("reserved state bits not zero");
  a_same_set_block: assert property (!o_state_word[SAME_SET_IRQ_ENABLE_BIT]
    && i_irq_req_set == o_state_word[15:10] |=> !o_irq_set_ok)
    else $error("same set interrupt allowed");
endmodule // csr_checker

bind cpu_control_status_regs csr_checker chk (.i_core_clk, .i_rst_n, .i_supervisor,
  .i_rd_req, .i_wr_req, .i_exc_take, .i_exc_is_irq, .i_exc_is_nmi, .i_state_restore,
  .i_irq_req_set, .o_rd_valid, .o_access_refused, .o_state_word, .o_saved_word,
  .o_irq_set_ok);

// ---- sim/cpu_control_status_regs_tb_top.sv ----
`timescale 1ns/1ns
module cpu_control_status_regs_tb_top;
  import cpu_ctl_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rd_req = 1'b0;
  logic wr_req = 1'b0;
  logic [4:0] num = 5'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [5:0] req_set = 6'h00;
  logic restore = 1'b0;
  logic [31:0] rword = 32'h0000_0000;
  logic sup, take, irq, brk, nmi;
  logic [5:0] eset;
  logic [31:0] cause, eaddr, rdata, state, saved;
  logic rvalid, refused, set_ok;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [4:0] absent [7] = '{5'h06, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h10, 5'h1F};

  core_exc_model pm (.i_core_clk(clk), .o_supervisor(sup), .o_exc_take(take),
    .o_exc_is_irq(irq), .o_exc_is_break(brk), .o_exc_is_nmi(nmi), .o_exc_set(eset),
    .o_exc_cause(cause), .o_exc_addr(eaddr));
  // Protection unit and interrupt interface with three shadow sets: 2-bit set fields
  cpu_control_status_regs #(.HAS_MPU(1'b1), .HAS_EIC(1'b1), .NUM_SHADOW_SETS(3)) uut (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_supervisor(sup), .i_rd_req(rd_req),
    .i_wr_req(wr_req), .i_reg_num(num), .i_wr_data(wdata), .i_exc_take(take),
    .i_exc_is_irq(irq), .i_exc_is_break(brk), .i_exc_is_nmi(nmi), .i_exc_set(eset),
    .i_exc_cause(cause), .i_exc_addr_valid(take), .i_exc_addr(eaddr),
    .i_state_restore(restore), .i_restore_word(rword), .i_irq_req_set(req_set),
    .o_rd_data(rdata), .o_rd_valid(rvalid), .o_access_refused(refused),
    .o_state_word(state), .o_saved_word(saved), .o_irq_set_ok(set_ok));

  initial begin
    forever #4 clk = ~clk;
  end
  // Hang guard: the whole sequence needs well under 400 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // Each access leaves an idle cycle so a request line is never set twice in one step
  task automatic wr(input logic [4:0] n, input logic [31:0] d);
    wr_req = 1'b1;
    num = n;
    wdata = d;
    tick();
    wr_req = 1'b0;
    chk("refused", {31'h0, ~sup}, {31'h0, refused});
    tick();
  endtask
  task automatic rd(input logic [4:0] n, input logic [31:0] exp);
    rd_req = 1'b1;
    num = n;
    tick();
    rd_req = 1'b0;
    chk("rd_valid", {31'h0, sup}, {31'h0, rvalid});
    chk("refused", {31'h0, ~sup}, {31'h0, refused});
    chk($sformatf("reg %0d", n), exp, rdata);
    tick();
  endtask
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rd(CTL_STATE_WORD, 32'h0080_0000);
    wr(CTL_CORE_ID, 32'hFFFF_FFFF);
    rd(CTL_CORE_ID, 32'h0000_0001);
    $display("test reset and identifier done");
    foreach (absent[i]) begin
      wr(absent[i], 32'hFFFF_FFFF);
      rd(absent[i], 32'h0000_0000);
    end
    for (int n = 12; n < 16; n++) begin
      wr(5'(n), 32'hA5A5_0000 | n);
      rd(5'(n), 32'hA5A5_0000 | n);
    end
    $display("test register map done");
    pm.set_mode(1'b0);
    wr(CTL_EXC_CAUSE, 32'h1234_5678);
    rd(CTL_EXC_CAUSE, 32'hA5A5_000F);
    pm.set_mode(1'b1);
    rd(CTL_EXC_CAUSE, 32'h0000_0000);
    $display("test user mode done");
    wr(CTL_STATE_WORD, 32'h00C3_0FFF);
    rd(CTL_STATE_WORD, 32'h0083_0FFF);
    wr(CTL_STATE_WORD, 32'h0080_0C00);
    pm.take(1'b0, 1'b0, 6'h00, 32'h0000_0BAD, 1'b0);
    chk("state", 32'h0083_0000, state);
    chk("saved", 32'h0080_0C00, saved);
    rd(CTL_EXC_CAUSE, 32'h0000_0BAD);
    rd(CTL_FAULT_ADDR, ~32'h0000_0BAD);
    pm.take(1'b1, 1'b1, 6'h06, 32'h0000_0010, 1'b0);
    chk("state", 32'h00C0_0800, state);
    chk("saved", 32'h0083_0000, saved);
    // Restore pulse: only configured fields and the nonmaskable bit come back
    restore = 1'b1;
    rword = 32'hFFFF_FFFF;
    tick();
    restore = 1'b0;
    chk("state", 32'h00C3_0FFF, state);
    wr(CTL_STATE_WORD, 32'h0080_0400);
    pm.take(1'b0, 1'b0, 6'h00, 32'h0000_0020, 1'b1);
    chk("state", 32'h00C1_0000, state);
    $display("test exceptions done");
    wr(CTL_STATE_WORD, 32'h0000_0800);
    req_set = 6'h02;
    tick();
    tick();
    chk("set_ok", 32'h0000_0000, {31'h0, set_ok});
    req_set = 6'h01;
    tick();
    tick();
    chk("set_ok", 32'h0000_0001, {31'h0, set_ok});
    wr(CTL_STATE_WORD, 32'h0080_0800);
    req_set = 6'h02;
    tick();
    tick();
    chk("set_ok", 32'h0000_0001, {31'h0, set_ok});
    $display("test same set gate done");
    // Mid-run reset must bring back the reset word and clear the gate output
    rst_n = 1'b0;
    tick();
    chk("set_ok", 32'h0000_0000, {31'h0, set_ok});
    tick();
    rst_n = 1'b1;
    rd(CTL_STATE_WORD, 32'h0080_0000);
    chk("saved", 32'h0000_0000, saved);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule // cpu_control_status_regs_tb_top
